// ---- upc_regs.vh ----
// upc_regs.vh: register offsets, field positions, reset values and counts
// of the upconverter profile and clock-multiplier control block.
// assumes: included by its bare name from the design files only.
`ifndef UPC_REGS_VH
`define UPC_REGS_VH

// register byte offsets on the ahb-lite slave
`define UPC_CTRL0_OFS 8'h00
`define UPC_CTRL1_OFS 8'h04
`define UPC_STATUS_OFS 8'h08
`define UPC_IRQ_STAT_OFS 8'h0c
`define UPC_IRQ_MASK_OFS 8'h10
`define UPC_LATENCY_OFS 8'h14
`define UPC_PROF_BASE 8'h20
`define UPC_PROF_FTW 2'h0
`define UPC_PROF_CFG 2'h1

// control register zero fields
`define UPC_MULT_LSB 0
`define UPC_MULT_MSB 4
`define UPC_LOCKCTL_BIT 5
`define UPC_CLEAR_BIT 7
`define UPC_MULT_BYPASS 5'h01
`define UPC_MULT_MIN 5'h04
`define UPC_MULT_MAX 5'h14
`define UPC_CTRL0_RST 8'h21

// control register one fields and mode codes
`define UPC_MODE_QUAD 2'h0
`define UPC_MODE_TONE 2'h1
`define UPC_MODE_INTERP 2'h2
`define UPC_SINC_BIT 2
`define UPC_SCALE_BIT 3
`define UPC_CTRL1_RST 4'h0

// profile config fields: [0] inverse filter bypass, [1] spectral invert,
// [7:2] interpolation rate, [15:8] output scale factor
`define UPC_RATE_BYPASS 6'h01
`define UPC_SCALE0_RST 8'hb5
`define UPC_RATE0_RST 6'h02

// interrupt status bits
`define UPC_IRQ_LOCK_LOST 0
`define UPC_IRQ_LOCK_GAIN 1
`define UPC_IRQ_PROFILE 2
`define UPC_IRQ_CLR_DONE 3
`define UPC_IRQ_W 4

// latency budget coefficients, in system clocks
`define UPC_LAT_ASM_MOD 7'd4
`define UPC_LAT_ASM_INT 7'd8
`define UPC_LAT_INVF 7'd12
`define UPC_LAT_FIXED 7'd72
`define UPC_LAT_PROG 7'd5
`define UPC_LAT_PROG_ADD 13'd9
`define UPC_LAT_MOD 13'd7
`define UPC_LAT_SINC 13'd7
`define UPC_LAT_SCALE 13'd6

// datapath clear routine length in divided-clock ticks
`define UPC_CLEAR_TICKS 8'h40

`endif

// ---- upc_sync.v ----
// upc_sync.v: three-stage synchroniser for pin inputs.
// assumes: inputs are asynchronous to clk; a new level is accepted once
// the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module upc_sync #(
  parameter W = 1,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  // first stage feeds only the second; the filter looks at 2 and 3
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      dout <= RST;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        dout <= s3_q;
    end
  end
endmodule // upc_sync
`default_nettype wire

// ---- upc_ctrl.v ----
// upc_ctrl.v: profile, clock-divider, lock housekeeping and input
// assembler control of a quadrature digital upconverter.
// assumes: hclk is the system clock; pins arrive asynchronously; the host
// drives sample data off our parallel data clock output.
//
// Overview of operation
// - latency register reports per-stage budget sum for the active profile
// - single-tone profile hop reaches tuning output well under 24 clocks
// - assembled sample appears three parallel-clock cycles after presented
// - assembler output captured at next rising edge of quarter-rate clock
// - parallel clock is system/2N, sample clock system/4N on its rises
// - divided clock ticks once every N system clocks, N 2..63 or 1
// - two select pins pick one of four profiles, upper pin is msb
// - each profile holds tuning word, invert, bypass, rate, gain
// - selects sampled on parallel clock, or every system clock in tone
// - zero tuning word forces phase accumulator to zero phase
// - multiplier value 01h bypasses and powers down the loop
// - multiplier values 04h to 14h multiply reference by that value
// - lock indicator output high while the loop is locked
// - unlocked with lock control clear: clear and hold whole datapath
// - holding conditions released on rising edge of the lock indicator
// - lock control set: indicator still driven, no holding actions
// - after lock loss with lock control clear, run full datapath clear once lock returns
`timescale 1ns/1ps
`default_nettype none
`include "upc_regs.vh"
module upc_ctrl #(
  parameter DW = 14
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  output reg irq,
  input wire pll_lock_raw,
  input wire profile_select_lsb,
  input wire profile_select_msb,
  input wire transmit_enable,
  input wire [DW-1:0] sample_data,
  output reg lock_indicator,
  output reg pll_powerdown,
  output reg [4:0] pll_multiplier,
  output reg parallel_data_clock,
  output reg sample_clock,
  output reg divided_tick,
  output reg [31:0] active_ftw,
  output reg [31:0] phase_acc,
  output reg zero_phase,
  output reg spectral_invert,
  output reg inv_filter_bypass,
  output reg [5:0] interp_rate,
  output reg [7:0] scale_factor,
  output reg accum_clear,
  output reg datapath_zero,
  output reg filter_clear,
  output reg tx_enable_out,
  output reg [DW-1:0] chain_sample
);
  // registers
  reg [7:0] ctrl0_q;
  reg [3:0] ctrl1_q;
  reg [`UPC_IRQ_W-1:0] irq_stat_q;
  reg [`UPC_IRQ_W-1:0] irq_mask_q;
  reg [31:0] ftw_q [0:3];
  reg [15:0] cfg_q [0:3];
  reg [12:0] latency_q;
  reg prof_chg_q;
  // ahb data phase state
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  // synchronised pins
  wire lock_s;
  wire [1:0] sel_s;
  // profile and divider state
  reg [1:0] prof_q;
  reg [5:0] div_cnt_q;
  reg lock_d1_q;
  reg loss_seen_q;
  reg clearing_q;
  reg [7:0] clr_cnt_q;
  reg [DW-1:0] asm0_q;
  reg [DW-1:0] asm1_q;
  reg [DW-1:0] asm2_q;
  // combinational helpers
  reg [31:0] rd_d;
  reg [12:0] lat_d;
  wire [5:0] n_eff;
  wire hold;
  wire pd_rise;
  wire sc_rise;
  wire acc_a;
  wire [7:0] a_ofs;
  wire [1:0] a_prof;
  wire [1:0] a_sub;
  wire a_is_prof;
  wire w_is_prof;
  wire [1:0] w_prof;
  wire lock_rise;
  wire lock_fall;
  wire clr_start;
  wire clr_done;
  wire [`UPC_IRQ_W-1:0] irq_set;
  wire [`UPC_IRQ_W-1:0] irq_clr;
  integer i;

  // lock pin and select pins pass four flops before any use
  upc_sync #(.W(1), .RST(1'b0)) u_lock_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .din(pll_lock_raw),
    .dout(lock_s)
  );
  upc_sync #(.W(2), .RST(2'b00)) u_sel_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .din({profile_select_msb, profile_select_lsb}),
    .dout(sel_s)
  );

  // holding only applies when lock monitoring is enabled
  assign hold = ~ctrl0_q[`UPC_LOCKCTL_BIT] & ~lock_s;
  assign lock_rise = lock_s & ~lock_d1_q;
  assign lock_fall = ~lock_s & lock_d1_q;
  // rate 1 or 0 means bypass, the divider then runs at full rate
  assign n_eff = (cfg_q[prof_q][7:2] <= `UPC_RATE_BYPASS) ?
                 6'd1 : cfg_q[prof_q][7:2];
  // parallel clock rises when it is low and the divider wraps
  assign pd_rise = divided_tick & ~parallel_data_clock & ~hold;
  assign sc_rise = pd_rise & ~sample_clock;
  assign clr_start = (ctrl0_q[`UPC_CLEAR_BIT] & ~clearing_q) |
                     (lock_rise & loss_seen_q &
                      ~ctrl0_q[`UPC_LOCKCTL_BIT]);
  // the count starts at zero, so the last of the ticks sees one less
  assign clr_done = clearing_q & divided_tick &
                    (clr_cnt_q == `UPC_CLEAR_TICKS - 8'h01);

  // ahb address decode
  assign acc_a = hsel & hready & htrans[1];
  assign a_ofs = haddr[7:0];
  // profiles sit at 20h plus 10h per profile, so bits 5:4 are offset by two
  assign a_is_prof = (a_ofs >= `UPC_PROF_BASE) &&
                     (a_ofs < `UPC_PROF_BASE + 8'h40);
  assign a_prof = a_ofs[5:4] ^ 2'b10;
  assign a_sub = a_ofs[3:2];
  assign w_is_prof = (wr_addr_q >= `UPC_PROF_BASE) &&
                     (wr_addr_q < `UPC_PROF_BASE + 8'h40);
  assign w_prof = wr_addr_q[5:4] ^ 2'b10;

  // read mux, evaluated in the address phase and registered
  always @* begin
    rd_d = 32'h0000_0000;
    if (a_is_prof) begin
      if (a_sub == `UPC_PROF_FTW)
        rd_d = ftw_q[a_prof];
      else if (a_sub == `UPC_PROF_CFG)
        rd_d = {16'h0000, cfg_q[a_prof]};
    end else begin
      case (a_ofs)
        `UPC_CTRL0_OFS: rd_d = {24'h00_0000, ctrl0_q};
        `UPC_CTRL1_OFS: rd_d = {28'h000_0000, ctrl1_q};
        `UPC_STATUS_OFS: rd_d = {26'h000_0000, clearing_q, hold,
                                 loss_seen_q, prof_q, lock_s};
        `UPC_IRQ_STAT_OFS: rd_d = {28'h000_0000, irq_stat_q};
        `UPC_IRQ_MASK_OFS: rd_d = {28'h000_0000, irq_mask_q};
        `UPC_LATENCY_OFS: rd_d = {19'h0_0000, latency_q};
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  // zero-wait slave: always ready, always okay
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wr_pend_q <= acc_a & hwrite;
        wr_addr_q <= a_ofs;
        if (acc_a & ~hwrite)
          hrdata <= rd_d;
      end
    end
  end

  // interrupt events; a set in the same cycle as a clear wins
  assign irq_set = {clr_done, prof_chg_q, lock_rise, lock_fall};
  assign irq_clr = (wr_pend_q && wr_addr_q == `UPC_IRQ_STAT_OFS) ?
                   hwdata[`UPC_IRQ_W-1:0] : {`UPC_IRQ_W{1'b0}};

  // software registers; the clear bit self-clears when the routine ends
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl0_q <= `UPC_CTRL0_RST;
      ctrl1_q <= `UPC_CTRL1_RST;
      irq_mask_q <= {`UPC_IRQ_W{1'b0}};
      irq_stat_q <= {`UPC_IRQ_W{1'b0}};
      for (i = 0; i < 4; i = i + 1) begin
        ftw_q[i] <= 32'h0000_0000;
        cfg_q[i] <= 16'h0000;
      end
      cfg_q[0] <= {`UPC_SCALE0_RST, `UPC_RATE0_RST, 2'b00};
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      if (clr_done)
        ctrl0_q[`UPC_CLEAR_BIT] <= 1'b0;
      if (wr_pend_q) begin
        if (w_is_prof) begin
          if (wr_addr_q[3:2] == `UPC_PROF_FTW)
            ftw_q[w_prof] <= hwdata;
          else if (wr_addr_q[3:2] == `UPC_PROF_CFG)
            cfg_q[w_prof] <= hwdata[15:0];
        end else begin
          case (wr_addr_q)
            `UPC_CTRL0_OFS: ctrl0_q <= {hwdata[7], 1'b0, hwdata[5:0]};
            `UPC_CTRL1_OFS: ctrl1_q <= hwdata[3:0];
            `UPC_IRQ_MASK_OFS: irq_mask_q <= hwdata[`UPC_IRQ_W-1:0];
            default: ;
          endcase
        end
      end
    end
  end

  // latency budget for the active profile and mode
  always @* begin
    lat_d = ((ctrl1_q[1:0] == `UPC_MODE_INTERP) ?
             `UPC_LAT_ASM_INT : `UPC_LAT_ASM_MOD) * n_eff;
    if (!cfg_q[prof_q][0])
      lat_d = lat_d + `UPC_LAT_INVF * n_eff;
    lat_d = lat_d + `UPC_LAT_FIXED * n_eff;
    lat_d = lat_d + `UPC_LAT_PROG * n_eff + `UPC_LAT_PROG_ADD;
    if (ctrl1_q[1:0] == `UPC_MODE_QUAD)
      lat_d = lat_d + `UPC_LAT_MOD;
    if (ctrl1_q[`UPC_SINC_BIT])
      lat_d = lat_d + `UPC_LAT_SINC;
    if (ctrl1_q[`UPC_SCALE_BIT])
      lat_d = lat_d + `UPC_LAT_SCALE;
  end

  // profile selection: tone mode samples every clock for fast hops
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prof_q <= 2'b00;
      prof_chg_q <= 1'b0;
      latency_q <= 13'h0000;
    end else begin
      latency_q <= lat_d;
      prof_chg_q <= 1'b0;
      if ((ctrl1_q[1:0] == `UPC_MODE_TONE || pd_rise) &&
          sel_s != prof_q) begin
        prof_q <= sel_s;
        prof_chg_q <= 1'b1;
      end
    end
  end

  // divider chain: tick every N clocks, parallel clock /2N, sample /4N;
  // the parallel clock is held low while holding
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= 6'h00;
      divided_tick <= 1'b0;
      parallel_data_clock <= 1'b0;
      sample_clock <= 1'b0;
    end else if (hold) begin
      div_cnt_q <= 6'h00;
      divided_tick <= 1'b0;
      parallel_data_clock <= 1'b0;
      sample_clock <= 1'b0;
    end else begin
      if (div_cnt_q >= n_eff - 6'd1) begin
        div_cnt_q <= 6'h00;
        divided_tick <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + 6'd1;
        divided_tick <= 1'b0;
      end
      if (divided_tick)
        parallel_data_clock <= ~parallel_data_clock;
      if (sc_rise)
        sample_clock <= 1'b1;
      else if (pd_rise)
        sample_clock <= 1'b0;
    end
  end

  // lock tracking and the datapath clear routine
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_d1_q <= 1'b0;
      loss_seen_q <= 1'b0;
      clearing_q <= 1'b0;
      clr_cnt_q <= 8'h00;
    end else begin
      lock_d1_q <= lock_s;
      if (lock_fall & ~ctrl0_q[`UPC_LOCKCTL_BIT])
        loss_seen_q <= 1'b1;
      else if (clr_start)
        loss_seen_q <= 1'b0;
      if (clr_start) begin
        clearing_q <= 1'b1;
        clr_cnt_q <= 8'h00;
      end else if (clr_done) begin
        clearing_q <= 1'b0;
      end else if (clearing_q & divided_tick) begin
        clr_cnt_q <= clr_cnt_q + 8'h01;
      end
    end
  end

  // input assembler: three parallel-clock stages, then sample-clock capture
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      asm0_q <= {DW{1'b0}};
      asm1_q <= {DW{1'b0}};
      asm2_q <= {DW{1'b0}};
      chain_sample <= {DW{1'b0}};
    end else if (hold | clearing_q) begin
      asm0_q <= {DW{1'b0}};
      asm1_q <= {DW{1'b0}};
      asm2_q <= {DW{1'b0}};
      chain_sample <= {DW{1'b0}};
    end else begin
      if (pd_rise) begin
        asm0_q <= sample_data;
        asm1_q <= asm0_q;
        asm2_q <= asm1_q;
      end
      // capture latency is always half a sample period, one parallel clock after the third stage loads
      if (sc_rise)
        chain_sample <= asm2_q;
    end
  end

  // tuning word path and phase accumulator
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_ftw <= 32'h0000_0000;
      phase_acc <= 32'h0000_0000;
      zero_phase <= 1'b1;
      spectral_invert <= 1'b0;
      inv_filter_bypass <= 1'b0;
      interp_rate <= 6'h00;
      scale_factor <= 8'h00;
    end else begin
      active_ftw <= ftw_q[prof_q];
      spectral_invert <= cfg_q[prof_q][1] &
                         (ctrl1_q[1:0] == `UPC_MODE_QUAD);
      inv_filter_bypass <= cfg_q[prof_q][0];
      interp_rate <= cfg_q[prof_q][7:2];
      scale_factor <= cfg_q[prof_q][15:8];
      zero_phase <= (ftw_q[prof_q] == 32'h0000_0000);
      if (hold | clearing_q | ftw_q[prof_q] == 32'h0000_0000)
        phase_acc <= 32'h0000_0000;
      else
        phase_acc <= phase_acc + ftw_q[prof_q];
    end
  end

  // loop programming, lock indicator, hold outputs and interrupt line
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_powerdown <= 1'b1;
      pll_multiplier <= `UPC_MULT_BYPASS;
      lock_indicator <= 1'b0;
      accum_clear <= 1'b0;
      datapath_zero <= 1'b0;
      filter_clear <= 1'b0;
      tx_enable_out <= 1'b0;
      irq <= 1'b0;
    end else begin
      pll_powerdown <= (ctrl0_q[4:0] == `UPC_MULT_BYPASS);
      // out-of-range codes fall back to bypass rather than a bad clock
      if (ctrl0_q[4:0] >= `UPC_MULT_MIN && ctrl0_q[4:0] <= `UPC_MULT_MAX)
        pll_multiplier <= ctrl0_q[4:0];
      else
        pll_multiplier <= `UPC_MULT_BYPASS;
      lock_indicator <= lock_s;
      accum_clear <= hold;
      datapath_zero <= hold | clearing_q;
      filter_clear <= hold | clearing_q;
      tx_enable_out <= transmit_enable & ~hold;
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end
endmodule // upc_ctrl
`default_nettype wire

// ---- upc_ctrl_fix_note_unused.v ----
`timescale 1ns/1ps

// ---- upc_ctrl_asserts.sv ----
// upc_ctrl_asserts.sv: port-level checker for the upconverter control block.
// assumes: bound to upc_ctrl, one clock domain, async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module upc_ctrl_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic pll_lock_raw,
  input wire logic transmit_enable,
  input wire logic lock_indicator,
  input wire logic pll_powerdown,
  input wire logic [4:0] pll_multiplier,
  input wire logic parallel_data_clock,
  input wire logic sample_clock,
  input wire logic [31:0] active_ftw,
  input wire logic [31:0] phase_acc,
  input wire logic tx_enable_out
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // the slave never stalls or errors
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus response not ready and okay");
  // a powered-down loop must present the bypass value
  mult_bypass_a: assert property (
    pll_powerdown |-> pll_multiplier == 5'h01)
    else $error("powerdown without bypass multiplier");
  mult_range_a: assert property (
    pll_multiplier == 5'h01 ||
    (pll_multiplier >= 5'h04 && pll_multiplier <= 5'h14))
    else $error("multiplier outside legal values");
  // indicator may only follow a pin level that has crossed the synchroniser
  lock_rise_a: assert property (
    $rose(lock_indicator) |-> $past(pll_lock_raw, 2))
    else $error("lock indicator rose without lock pin");
  lock_fall_a: assert property (
    $fell(lock_indicator) |-> !$past(pll_lock_raw, 2))
    else $error("lock indicator fell with lock pin high");
  tx_gate_a: assert property (
    tx_enable_out |-> $past(transmit_enable))
    else $error("transmit enable passed without request");
  phase_zero_a: assert property (
    (active_ftw == 32'h0)[*3] |-> phase_acc == 32'h0)
    else $error("zero tuning word left phase running");
  sclk_on_pd_a: assert property (
    $rose(sample_clock) |-> parallel_data_clock)
    else $error("sample clock rose off a parallel clock rise");
endmodule // upc_ctrl_asserts

bind upc_ctrl upc_ctrl_asserts upc_ctrl_asserts_inst (.hclk, .hresetn,
  .hreadyout, .hresp, .pll_lock_raw, .transmit_enable, .lock_indicator,
  .pll_powerdown, .pll_multiplier, .parallel_data_clock, .sample_clock,
  .active_ftw, .phase_acc, .tx_enable_out);
`default_nettype wire

// ---- upc_host_model.sv ----
// upc_host_model.sv: host logic driving samples and profile pins.
// assumes: samples launched after each parallel clock rise; pins async.
`timescale 1ns/1ps
`default_nettype none
module upc_host_model (
  input wire logic parallel_data_clock,
  input wire logic [1:0] prof_req,
  input wire logic tx_req,
  output logic profile_select_lsb,
  output logic profile_select_msb,
  output logic transmit_enable,
  output logic [13:0] sample_data
);
  // profile index as binary code, upper pin is the msb
  assign #2 {profile_select_msb, profile_select_lsb} = prof_req;
  assign #2 transmit_enable = tx_req;
  // a counting sample makes each word traceable through the assembler
  initial sample_data = 14'h0001;
  always @(posedge parallel_data_clock) sample_data <= sample_data + 14'h0001;
endmodule // upc_host_model
`default_nettype wire

// ---- upc_ctrl_bench.sv ----
// upc_ctrl_bench.sv: self-checking bench for the upconverter control block.
// assumes: 100 MHz hclk, ahb-lite master tasks, host model on the pins.
`timescale 1ns/1ps
`default_nettype none
module upc_ctrl_bench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic pll_lock_raw, profile_select_lsb, profile_select_msb, tx_req;
  logic transmit_enable, lock_indicator, pll_powerdown, zero_phase;
  logic parallel_data_clock, sample_clock, divided_tick, spectral_invert;
  logic inv_filter_bypass, accum_clear, datapath_zero, filter_clear;
  logic tx_enable_out;
  logic [31:0] haddr, hwdata, hrdata, active_ftw, phase_acc, rv;
  logic [1:0] htrans, prof_req;
  logic [2:0] hsize;
  logic [4:0] pll_multiplier;
  logic [5:0] interp_rate;
  logic [7:0] scale_factor;
  logic [13:0] sample_data, chain_sample;
  int err_count, checks;

  upc_ctrl upc_ctrl_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .irq,
    .pll_lock_raw, .profile_select_lsb, .profile_select_msb,
    .transmit_enable, .sample_data, .lock_indicator, .pll_powerdown,
    .pll_multiplier, .parallel_data_clock, .sample_clock, .divided_tick,
    .active_ftw, .phase_acc, .zero_phase, .spectral_invert,
    .inv_filter_bypass, .interp_rate, .scale_factor, .accum_clear,
    .datapath_zero, .filter_clear, .tx_enable_out, .chain_sample);
  upc_host_model upc_host_model_inst (.parallel_data_clock, .prof_req,
    .tx_req, .profile_select_lsb, .profile_select_msb, .transmit_enable,
    .sample_data);

  // single slave: its ready output is the bus ready
  assign hready = hreadyout;

  // system clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // single transfer; only the watchdog ends a wait on a stuck slave
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rv = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rv);
  endtask

  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // rises counted at the falling edge, clear of the launching edge
  task count(input int c, output int pr, output int sr, output int tk);
    logic pp, sp;
    pr = 0;
    sr = 0;
    tk = 0;
    @(negedge hclk);
    pp = parallel_data_clock;
    sp = sample_clock;
    repeat (c) begin
      @(negedge hclk);
      if (parallel_data_clock && !pp) pr++;
      if (sample_clock && !sp) sr++;
      if (divided_tick) tk++;
      pp = parallel_data_clock;
      sp = sample_clock;
    end
  endtask

  task t_reset;
    rdc("ctrl0", 8'h00, 32'h0000_0021);
    rdc("ctrl1", 8'h04, 32'h0);
    rdc("prof0 cfg", 8'h24, 32'h0000_b508);
    rdc("prof1 cfg", 8'h34, 32'h0);
    wr(8'h18, 32'hffff_ffff);
    rdc("unmapped", 8'h18, 32'h0);
    chk("powerdown", 1, pll_powerdown);
    chk("lock", 1, lock_indicator);
    $display("test reset done");
  endtask

  task t_mult;
    logic [4:0] fv [5] = '{5'h01, 5'h04, 5'h14, 5'h15, 5'h03};
    logic [4:0] em [5] = '{5'h01, 5'h04, 5'h14, 5'h01, 5'h01};
    // 14h assumes a 10 MHz reference, so the product stays at 200 MHz
    for (int i = 0; i < 5; i++) begin
      wr(8'h00, {27'h1, fv[i]});
      cyc(2);
      chk("multiplier", em[i], pll_multiplier);
      chk("powerdown", i == 0, pll_powerdown);
    end
    wr(8'h00, 32'h0000_0021);
    $display("test multiplier done");
  endtask

  task t_prof;
    int n;
    logic [31:0] e;
    wr(8'h04, 32'h1);
    for (int p = 0; p < 4; p++) wr(8'h20 + 8'(p * 16), 32'h0100_0000 * (p + 1));
    wr(8'h0c, 32'hf);
    wr(8'h10, 32'h4);
    for (int k = 1; k < 5; k++) begin
      e = 32'h0100_0000 * ((k % 4) + 1);
      prof_req <= 2'(k);
      for (n = 0; n < 40 && active_ftw !== e; n++) @(posedge hclk);
      chk("hop in time", 1, n < 24);
      cyc(3);
      chk("profile irq", 1, irq);
      chk("phase running", 0, zero_phase);
      wr(8'h0c, 32'h4);
      cyc(2);
      chk("irq cleared", 0, irq);
    end
    wr(8'h10, 32'h0);
    prof_req <= 2'h1;
    cyc(20);
    chk("masked irq", 0, irq);
    xfer(1'b0, 8'h0c, 32'h0);
    chk("profile event", 32'h4, rv & 32'h4);
    wr(8'h30, 32'h0);
    cyc(6);
    chk("zero phase", 1, zero_phase);
    chk("phase acc", 32'h0, phase_acc);
    prof_req <= 2'h0;
    cyc(10);
    wr(8'h04, 32'h0);
    $display("test profile done");
  endtask

  task t_lat;
    rdc("latency quad", 8'h14, 32'h0000_00ca);
    wr(8'h04, 32'h0000_000e);
    rdc("latency interp", 8'h14, 32'h0000_00d8);
    wr(8'h04, 32'h0);
    $display("test latency done");
  endtask

  task t_rate;
    int pr, sr, tk, n;
    for (int i = 0; i < 2; i++) begin
      n = i ? 5 : 2;
      wr(8'h24, 32'h0000_b503 | 32'(n << 2));
      cyc(20);
      chk("profile fields", {8'hb5, 6'(n), 2'b11}, {scale_factor,
        interp_rate, spectral_invert, inv_filter_bypass});
      count(120, pr, sr, tk);
      chk("pd rises", 120 / (2 * n), pr);
      chk("sample rises", 120 / (4 * n), sr);
      chk("div ticks", 120 / n, tk);
    end
    wr(8'h24, 32'h0000_b508);
    $display("test rates done");
  endtask

  task t_asm;
    logic [13:0] d;
    tx_req <= 1'b1;
    cyc(10);
    chk("tx passed", 1, tx_enable_out);
    cyc(40);
    @(posedge sample_clock);
    #1;
    d = sample_data - chain_sample;
    chk("asm latency", 1, d >= 14'h3 && d <= 14'h5);
    $display("test assembler done");
  endtask

  task t_lock;
    int pr, sr, tk, n;
    wr(8'h00, 32'h04);
    wr(8'h10, 32'h9);
    wr(8'h0c, 32'hf);
    pll_lock_raw <= 1'b0;
    cyc(10);
    chk("lock low", 0, lock_indicator);
    chk("loss irq", 1, irq);
    chk("tx gated", 0, tx_enable_out);
    chk("hold", 3'h7, {accum_clear, datapath_zero, filter_clear});
    count(40, pr, sr, tk);
    chk("pd held", 0, pr);
    chk("pd low", 0, parallel_data_clock);
    xfer(1'b0, 8'h08, 32'h0);
    chk("holding", 32'h10, rv & 32'h10);
    wr(8'h0c, 32'hf);
    cyc(2);
    chk("w1c", 0, irq);
    pll_lock_raw <= 1'b1;
    for (n = 0; n < 20 && lock_indicator !== 1'b1; n++) @(posedge hclk);
    xfer(1'b0, 8'h08, 32'h0);
    chk("clearing", 32'h20, rv & 32'h20);
    count(20, pr, sr, tk);
    chk("pd resumes", 1, pr > 0);
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge hclk);
    chk("clear done", 1, irq);
    chk("clear length", 1, n > 95 && n < 115);
    chk("tx resumes", 1, tx_enable_out);
    wr(8'h0c, 32'hf);
    wr(8'h00, 32'h24);
    pll_lock_raw <= 1'b0;
    cyc(10);
    chk("lock low", 0, lock_indicator);
    count(40, pr, sr, tk);
    chk("pd runs", 1, pr > 0);
    chk("tx kept", 1, tx_enable_out);
    chk("no hold", 0, accum_clear);
    chk("loss flagged", 1, irq);
    pll_lock_raw <= 1'b1;
    cyc(10);
    wr(8'h0c, 32'hf);
    wr(8'h10, 32'h0);
    cyc(2);
    chk("irq idle", 0, irq);
    $display("test lock done");
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pll_lock_raw = 1'b1;
    prof_req = 2'h0;
    tx_req = 1'b0;
    err_count = 0;
    checks = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(2);
    t_reset;
    t_mult;
    t_prof;
    t_lat;
    t_rate;
    t_asm;
    t_lock;
    print_verdict;
  end

  // the whole run needs well under 10k cycles
  initial begin
    #400_000;
    err_count++;
    $display("watchdog expired");
    print_verdict;
  end
endmodule // upc_ctrl_bench
`default_nettype wire
